// *** hdl/speed_profile_control_status.sv ***
// Command word decoder and state word composer for the speed profile
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_defs.svh"

module speed_profile_control_status #(
  parameter int FAULT_COUNT = `EVENT_COUNT,
  parameter int WARN_COUNT  = `EVENT_COUNT
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset_n,
  input  wire logic [`WORD_WIDTH-1:0]            command_word_in,
  input  wire logic                              command_strobe,
  input  wire logic [`WORD_WIDTH-1:0]            process_data_in,
  input  wire speed_profile_pkg::drive_feedback_t feedback,
  input  wire logic [FAULT_COUNT-1:0]            fault_condition,
  input  wire logic [WARN_COUNT-1:0]             warn_condition,
  output logic      [`WORD_WIDTH-1:0]            drive_command_word,
  output logic      [`WORD_WIDTH-1:0]            drive_state_word,
  output var speed_profile_pkg::drive_command_t  command_out,
  output logic      [`WORD_WIDTH-1:0]            speed_reference,
  output logic                                   start_pulse,
  output logic                                   run_enable,
  output logic                                   fieldbus_input_one_select,
  output logic                                   fieldbus_input_two_select,
  output logic                                   fieldbus_input_three_select,
  output logic                                   fieldbus_input_four_select,
  output logic      [FAULT_COUNT-1:0]            fault_latched,
  output logic      [WARN_COUNT-1:0]             warn_latched
);

  import speed_profile_pkg::*;

  localparam int FB_INPUTS = `CMD_FB_INPUT_HI - `CMD_FB_INPUT_LO + 1;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`WORD_WIDTH-1:0] command_word_q;
  logic [`WORD_WIDTH-1:0] active_word_q;
  logic [`WORD_WIDTH-1:0] active_word_d;
  logic [`WORD_WIDTH-1:0] process_data_q;
  logic [`WORD_WIDTH-1:0] state_word_q;
  logic [`WORD_WIDTH-1:0] state_word_d;
  logic [FB_INPUTS-1:0]   fb_input_q;
  logic                   data_valid_in;
  logic                   fieldbus_in_charge;
  logic                   accept;
  logic                   event_reset_prev_q;
  logic                   event_reset_pulse;
  logic                   start_prev_q;
  logic                   start_edge;
  logic                   start_pulse_q;
  logic                   run_enable_q;
  logic                   any_fault;
  logic                   any_warning;
  logic                   coast_now;
  logic [FAULT_COUNT-1:0] fault_latched_w;
  logic [WARN_COUNT-1:0]  warn_latched_w;

  // ----------------------------------------------------------------
  // Command word capture
  // ----------------------------------------------------------------
  // The raw word is always kept so software sees what was last written,
  // even when the drive is not taking it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      command_word_q <= `WORD_RESET;
    end else if (command_strobe) begin
      command_word_q <= command_word_in;
    end
  end

  // A write is acted on only with data valid set and fieldbus in charge
  assign data_valid_in      = command_word_in[`CMD_DATA_VALID];
  assign fieldbus_in_charge = feedback.fieldbus_place;
  assign accept             = command_strobe & data_valid_in &
                              fieldbus_in_charge;

  // ----------------------------------------------------------------
  // Accepted command word
  // ----------------------------------------------------------------
  // Reserved bits 2, 8 and 11 are dropped here so nothing downstream
  // can ever react to them
  always_comb begin
    active_word_d                   = command_word_in;
    active_word_d[2]                = 1'b0;
    active_word_d[8]                = 1'b0;
    active_word_d[11]               = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      active_word_q <= `WORD_RESET;
    end else if (accept) begin
      active_word_q <= active_word_d;
    end
  end

  // ----------------------------------------------------------------
  // Process data
  // ----------------------------------------------------------------
  // With data valid low the last accepted reference simply stays put
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      process_data_q <= `WORD_RESET;
    end else if (accept) begin
      process_data_q <= process_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Fieldbus digital inputs
  // ----------------------------------------------------------------
  // Captured only on an accepted write, like every other command bit
  genvar gi;
  generate
    for (gi = 0; gi < FB_INPUTS; gi++) begin : g_fb_input
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          fb_input_q[gi] <= 1'b0;
        end else if (accept) begin
          fb_input_q[gi] <= command_word_in[`CMD_FB_INPUT_LO + gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event reset edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      event_reset_prev_q <= 1'b0;
    end else begin
      event_reset_prev_q <= active_word_q[`CMD_EVENT_RESET];
    end
  end

  // Only the edge counts; holding the bit high clears nothing more
  assign event_reset_pulse = active_word_q[`CMD_EVENT_RESET] &
                             ~event_reset_prev_q;

  // ----------------------------------------------------------------
  // Event latches
  // ----------------------------------------------------------------
  // Faults also block starting until they are released
  event_latch_bank #(
    .COUNT (FAULT_COUNT)
  ) u_fault_latches (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .condition     (fault_condition),
    .release_pulse (event_reset_pulse),
    .latched       (fault_latched_w)
  );

  // Warnings only report; they never stop the drive here
  event_latch_bank #(
    .COUNT (WARN_COUNT)
  ) u_warn_latches (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .condition     (warn_condition),
    .release_pulse (event_reset_pulse),
    .latched       (warn_latched_w)
  );

  // ----------------------------------------------------------------
  // Event summary
  // ----------------------------------------------------------------
  // A latched event counts, live or not, until a reset pulse drops it
  assign any_fault   = |fault_latched_w;
  assign any_warning = |warn_latched_w;

  // ----------------------------------------------------------------
  // Start edge
  // ----------------------------------------------------------------
  // Edge memory follows the accepted bit, so a refused write cannot
  // fake an edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= active_word_q[`CMD_START];
    end
  end

  assign start_edge = active_word_q[`CMD_START] & ~start_prev_q;

  // ----------------------------------------------------------------
  // Coast
  // ----------------------------------------------------------------
  // Either the drive core or the master may hold the drive in coast
  assign coast_now = feedback.coast_active |
                     ~active_word_q[`CMD_COAST_N];

  // ----------------------------------------------------------------
  // Start pulse and run enable
  // ----------------------------------------------------------------
  // A start edge seen during a fault is lost, not queued: the master
  // must raise the start bit again after the fault is reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_pulse_q <= 1'b0;
    end else begin
      start_pulse_q <= start_edge & ~any_fault & ~coast_now;
    end
  end

  // Any stop cause beats a start edge in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_enable_q <= 1'b0;
    end else if (!active_word_q[`CMD_START] || any_fault || coast_now) begin
      run_enable_q <= 1'b0;
    end else if (start_edge) begin
      run_enable_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State word
  // ----------------------------------------------------------------
  always_comb begin
    state_word_d                     = `WORD_RESET;
    state_word_d[`STS_CONTROL_READY] = feedback.control_ready;
    state_word_d[`STS_DRIVE_READY]   = feedback.drive_ready;
    state_word_d[`STS_NO_COAST]      = ~coast_now;
    state_word_d[`STS_FAULT]         = any_fault;
    state_word_d[`STS_WARNING]       = any_warning;
    state_word_d[`STS_AT_REFERENCE]  = feedback.speed_at_ref;
    state_word_d[`STS_FIELDBUS_CTRL] = feedback.fieldbus_place;
    state_word_d[`STS_LIMITER]       = feedback.limiter_active;
    state_word_d[`STS_OPERATION]     = feedback.modulating;
  end

  // ----------------------------------------------------------------
  // State word register
  // ----------------------------------------------------------------
  // Registered so the master never reads a word that is mid-change
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_word_q <= `WORD_RESET;
    end else begin
      state_word_q <= state_word_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign drive_command_word = command_word_q;
  assign drive_state_word   = state_word_q;
  assign speed_reference    = process_data_q;
  assign start_pulse        = start_pulse_q;
  assign run_enable         = run_enable_q;
  assign fault_latched      = fault_latched_w;
  assign warn_latched       = warn_latched_w;

  // ----------------------------------------------------------------
  // Accepted command fields
  // ----------------------------------------------------------------
  // One process drives the whole struct, so it has a single driver
  always_comb begin
    command_out.preset_sel   =
      active_word_q[`CMD_PRESET_HI:`CMD_PRESET_LO];
    command_out.coast_n      = active_word_q[`CMD_COAST_N];
    command_out.quick_stop_n = active_word_q[`CMD_QUICK_STOP_N];
    command_out.ref_free     = active_word_q[`CMD_REF_FREE];
    command_out.start_level  = active_word_q[`CMD_START];
    command_out.ramp_sel     = active_word_q[`CMD_RAMP_SEL];
  end

  // ----------------------------------------------------------------
  // Fieldbus digital inputs out
  // ----------------------------------------------------------------
  assign fieldbus_input_one_select   = fb_input_q[0];
  assign fieldbus_input_two_select   = fb_input_q[1];
  assign fieldbus_input_three_select = fb_input_q[2];
  assign fieldbus_input_four_select  = fb_input_q[3];

endmodule

`default_nettype wire

// *** hdl/speed_profile_defs.svh ***
// Bit positions, widths and reset values of the speed profile words
`ifndef SPEED_PROFILE_DEFS_SVH
`define SPEED_PROFILE_DEFS_SVH

// ----------------------------------------------------------------
// Word geometry
// ----------------------------------------------------------------
`define WORD_WIDTH        16
`define WORD_RESET        16'h0000
`define EVENT_COUNT       8

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define CMD_PRESET_LO     0
`define CMD_PRESET_HI     1
`define CMD_COAST_N       3
`define CMD_QUICK_STOP_N  4
`define CMD_REF_FREE      5
`define CMD_START         6
`define CMD_EVENT_RESET   7
`define CMD_RAMP_SEL      9
`define CMD_DATA_VALID    10
`define CMD_FB_INPUT_LO   12
`define CMD_FB_INPUT_HI   15

// ----------------------------------------------------------------
// State word fields
// ----------------------------------------------------------------
`define STS_CONTROL_READY 0
`define STS_DRIVE_READY   1
`define STS_NO_COAST      2
`define STS_FAULT         3
`define STS_WARNING       7
`define STS_AT_REFERENCE  8
`define STS_FIELDBUS_CTRL 9
`define STS_LIMITER       10
`define STS_OPERATION     11

`endif

// *** hdl/speed_profile_pkg.sv ***
// Types shared by the speed profile command and state logic
package speed_profile_pkg;

  // Live condition levels reported by the drive core
  typedef struct packed {
    logic control_ready;
    logic drive_ready;
    logic coast_active;
    logic speed_at_ref;
    logic limiter_active;
    logic modulating;
    logic fieldbus_place;
  } drive_feedback_t;

  // Accepted commands as the drive core should act on them
  typedef struct packed {
    logic [1:0] preset_sel;
    logic       coast_n;
    logic       quick_stop_n;
    logic       ref_free;
    logic       start_level;
    logic       ramp_sel;
  } drive_command_t;

endpackage

// *** hdl/event_latch_bank.sv ***
// Sticky event latches released by an event reset pulse
`timescale 1ns/1ps
`default_nettype none

module event_latch_bank #(
  parameter int COUNT = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [COUNT-1:0] condition,
  input  wire logic             release_pulse,
  output logic      [COUNT-1:0] latched
);

  logic [COUNT-1:0] latched_q;

  // ----------------------------------------------------------------
  // One latch per event
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < COUNT; i++) begin : g_event
      // A live condition keeps or sets the latch, so a reset pulse can
      // only drop events whose cause has gone; set beats clear
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          latched_q[i] <= 1'b0;
        end else begin
          latched_q[i] <= condition[i] |
                          (latched_q[i] & ~release_pulse);
        end
      end
    end
  endgenerate

  assign latched = latched_q;

endmodule

`default_nettype wire

// *** tb/speed_profile_checker_asserts.sv ***
// Concurrent checks on the speed profile command and state ports
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_defs.svh"

module speed_profile_checker #(
  parameter int FAULT_COUNT = 8,
  parameter int WARN_COUNT  = 8
) (
  input wire logic                               clk_sys,
  input wire logic                               reset_n,
  input wire logic [`WORD_WIDTH-1:0]             command_word_in,
  input wire logic                               command_strobe,
  input wire logic [`WORD_WIDTH-1:0]             process_data_in,
  input wire speed_profile_pkg::drive_feedback_t feedback,
  input wire logic [FAULT_COUNT-1:0]             fault_condition,
  input wire logic [FAULT_COUNT-1:0]             fault_latched,
  input wire logic [`WORD_WIDTH-1:0]             drive_command_word,
  input wire logic [`WORD_WIDTH-1:0]             drive_state_word,
  input wire speed_profile_pkg::drive_command_t  command_out,
  input wire logic [`WORD_WIDTH-1:0]             speed_reference,
  input wire logic                               start_pulse
);
  import speed_profile_pkg::*;
  // ----
  // Checks
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic acc;
  assign acc = command_strobe & command_word_in[10] & feedback.fieldbus_place;

  raw_word_a: assert property (command_strobe |=>
    drive_command_word == $past(command_word_in)) else $error("raw lost");
  ref_take_a: assert property (acc |=>
    speed_reference == $past(process_data_in)) else $error("ref not taken");
  refuse_hold_a: assert property (command_strobe && !acc |=>
    $stable(speed_reference) && $stable(command_out))
    else $error("refused word acted on");
  ramp_sel_a: assert property (acc |=>
    command_out.ramp_sel == $past(command_word_in[9])) else $error("ramp");
  preset_sel_a: assert property (acc |=>
    command_out.preset_sel == $past(command_word_in[1:0]))
    else $error("preset");
  reserved_zero_a: assert property (drive_state_word[6:4] == 3'h0 &&
    drive_state_word[15:12] == 4'h0) else $error("reserved bit set");
  fault_flag_a: assert property ($past(reset_n) |->
    drive_state_word[3] == |$past(fault_latched)) else $error("fault flag");
  state_mirror_a: assert property ($past(reset_n) |->
    {drive_state_word[11:8], drive_state_word[1:0]} ==
    $past({feedback.modulating, feedback.limiter_active,
    feedback.fieldbus_place, feedback.speed_at_ref,
    feedback.drive_ready, feedback.control_ready}))
    else $error("state mirror");
  event_hold_a: assert property ($past(reset_n) |->
    (fault_latched & $past(fault_condition)) == $past(fault_condition))
    else $error("live event dropped");
  start_fault_a: assert property (start_pulse |->
    !(|$past(fault_latched))) else $error("start during fault");

  cover property (acc && command_word_in[7]);
  cover property (start_pulse);
  cover property (command_strobe && !acc);
endmodule

bind speed_profile_control_status speed_profile_checker #(
  .FAULT_COUNT(FAULT_COUNT), .WARN_COUNT(WARN_COUNT)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .command_word_in(command_word_in),
  .command_strobe(command_strobe), .process_data_in(process_data_in),
  .feedback(feedback), .fault_condition(fault_condition),
  .fault_latched(fault_latched), .drive_command_word(drive_command_word),
  .drive_state_word(drive_state_word), .command_out(command_out),
  .speed_reference(speed_reference), .start_pulse(start_pulse));
`default_nettype wire

// *** tb/fieldbus_master_model.sv ***
// Behavioural fieldbus master handing command and process data pairs
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_defs.svh"

module fieldbus_master_model (
  input  wire logic                   clk_sys,
  output logic      [`WORD_WIDTH-1:0] command_word_in,
  output logic                        command_strobe,
  output logic      [`WORD_WIDTH-1:0] process_data_in
);
  initial begin
    command_word_in = 16'h0000;
    command_strobe  = 1'b0;
    process_data_in = 16'h0000;
  end

  // Words are not held between strobes: showing the inverse catches a
  // receiver that samples them off the strobe
  task automatic send(input logic [15:0] word, input logic [15:0] data);
    @(negedge clk_sys);
    command_word_in = word;
    process_data_in = data;
    command_strobe  = 1'b1;
    @(negedge clk_sys);
    command_strobe  = 1'b0;
    command_word_in = ~word;
    process_data_in = ~data;
  endtask
endmodule
`default_nettype wire

// *** tb/speed_profile_control_status_tb.sv ***
// Self-checking bench for the speed profile command and state block
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_defs.svh"

module speed_profile_control_status_tb;
  import speed_profile_pkg::*;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic [`WORD_WIDTH-1:0] cw, pd, dcw, dsw, sref;
  logic                   cs, sp, run;
  wire logic [3:0]        fbin;
  logic [7:0]             fc = 8'h00, wc = 8'h00, fl, wl;
  drive_feedback_t        fb = 7'h01;
  drive_command_t         co;
  int                     err_count = 0;
  int                     tests_run = 0;

  always #4 clk_sys = ~clk_sys;

  fieldbus_master_model master (.clk_sys(clk_sys), .command_word_in(cw),
    .command_strobe(cs), .process_data_in(pd));

  speed_profile_control_status #(.FAULT_COUNT(8), .WARN_COUNT(8)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .command_word_in(cw),
    .command_strobe(cs), .process_data_in(pd), .feedback(fb),
    .fault_condition(fc), .warn_condition(wc), .drive_command_word(dcw),
    .drive_state_word(dsw), .command_out(co), .speed_reference(sref),
    .start_pulse(sp), .run_enable(run),
    .fieldbus_input_one_select(fbin[0]), .fieldbus_input_two_select(fbin[1]),
    .fieldbus_input_three_select(fbin[2]),
    .fieldbus_input_four_select(fbin[3]),
    .fault_latched(fl), .warn_latched(wl));

  // ----
  // Helpers
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  // Reserved bits 8, 11 and 2 are set and must change nothing
  task automatic t_accept;
    master.send(16'h5f07, 16'h1234);
    check(dcw, 16'h5f07);
    check(sref, 16'h1234);
    check(fbin, 4'h5);
    check(co, 7'h61);
    $display("accept test done");
  endtask

  task automatic t_refuse;
    master.send(16'h3203, 16'habcd);
    check(dcw, 16'h3203);
    check(sref, 16'h1234);
    check(fbin, 4'h5);
    fb = 7'h00;
    master.send(16'h0400, 16'h5555);
    check(sref, 16'h1234);
    check(co, 7'h61);
    $display("refuse test done");
  endtask

  task automatic t_status;
    fb = 7'h6f;
    master.send(16'h0408, 16'h0000);
    tick(1);
    check(dsw, 16'h0f07);
    fb = 7'h7f;
    tick(2);
    check(dsw, 16'h0f03);
    fb = 7'h01;
    tick(2);
    check(dsw, 16'h0204);
    $display("status test done");
  endtask

  task automatic t_event;
    fc = 8'h03;
    wc = 8'h80;
    tick(1);
    fc = 8'h02;
    wc = 8'h00;
    tick(2);
    check(fl, 8'h03);
    check(dsw, 16'h028c);
    master.send(16'h0448, 16'h0000);
    tick(1);
    check(sp, 1'b0);
    check(run, 1'b0);
    master.send(16'h0488, 16'h0000);
    tick(1);
    check(fl, 8'h02);
    check(wl, 8'h00);
    tick(1);
    check(dsw, 16'h020c);
    fc = 8'h00;
    master.send(16'h0408, 16'h0000);
    master.send(16'h0488, 16'h0000);
    tick(2);
    check(fl, 8'h00);
    $display("event test done");
  endtask

  task automatic t_start;
    master.send(16'h0448, 16'h0100);
    tick(1);
    check(sp, 1'b1);
    check(run, 1'b1);
    tick(1);
    check(sp, 1'b0);
    master.send(16'h0408, 16'h0100);
    tick(2);
    check(run, 1'b0);
    $display("start test done");
  endtask

  initial begin
    tick(2);
    reset_n = 1'b1;
    t_accept();
    t_refuse();
    t_status();
    t_event();
    t_start();
    end_sim();
  end
endmodule
`default_nettype wire
